// file: design/pcid_regs.sv
// Configuration identification register bank with APB slave.
// Assumes an APB master on SYS_CLK; tie-off pins are static straps.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Identification registers are hard-wired read-only; upper 24 bits read zero here.
// - Third byte high nibble returns fixed architecture version.
// - Third byte bit 3 always reads one.
// - Third byte low three bits return upper maker code bits.
// - Fourth byte high nibble comes from four AND-gate tie-offs.
// - Fourth byte low nibble holds customer modification number.
// - Combined word bit 31 security support, bits 30:28 priority code.
// - Bits 27:18 hold shared interrupt count; zero and above 988 reserved.
// - Bits 17:13 hold private interrupt count, maximum sixteen.
// - Sixth byte low five bits hold software interrupt count, maximum sixteen.
// - Fifth byte high nibble is log2 of 4KB block count, zero.
// - Fifth byte low nibble is maker continuation count constant.
// - Sixth byte bits 7:5 carry low three private count bits.
// - Seventh byte: private count MSBs low, shared count LSBs above.
// - Eighth byte low nibble carries shared count top four bits.
// - Priority code 0..4 maps to 16..256 levels; 5..7 reserved.
// - Security bit zero for secure only, one for both states.
module pcid_regs (
  input  wire logic                           SYS_CLK,
  input  wire logic                           RST_N,
  input  wire logic                           CLK_EN,
  input  wire logic [3:0]                     METAL_FIX_REVISION,
  input  wire logic [pcid_pkg::ADDR_WIDTH-1:0] PADDR,
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [pcid_pkg::DATA_WIDTH-1:0] PWDATA,
  output logic      [pcid_pkg::DATA_WIDTH-1:0] PRDATA,
  output logic                                PREADY,
  output logic                                PSLVERR
);
  import pcid_pkg::*;

  logic [3:0]  fix_meta_reg;
  logic [3:0]  fix_sync_reg;
  logic [3:0]  fix_meta_next;
  logic [3:0]  fix_sync_next;
  logic [3:0]  fix_gated;
  logic [7:0]  val_two;
  logic [7:0]  val_three;
  logic [7:0]  val_four;
  logic [7:0]  val_five;
  logic [7:0]  val_six;
  logic [7:0]  val_seven;
  logic [31:0] word_two;
  logic [31:0] word_three;
  logic [31:0] word_four;
  logic [31:0] word_five;
  logic [31:0] word_six;
  logic [31:0] word_seven;
  logic [31:0] config_word;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic        valid_reg;
  logic        valid_next;

  // Revision straps come from pins: two stages before use
  always_comb begin
    fix_meta_next = fix_meta_reg;
    fix_sync_next = fix_sync_reg;
    if (CLK_EN) begin
      fix_meta_next = METAL_FIX_REVISION;
      fix_sync_next = fix_meta_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      fix_meta_reg <= 4'h0;
      fix_sync_reg <= 4'h0;
    end else begin
      fix_meta_reg <= fix_meta_next;
      fix_sync_reg <= fix_sync_next;
    end
  end

  // Four AND gates; a metal fix alters the second input
  assign fix_gated = fix_sync_reg & 4'hF;

  assign val_two   = {ARCH_VERSION, MAKER_ALLOCATED, MAKER_CODE_HIGH};
  assign val_three = {fix_gated | METAL_FIX_DEFAULT, MOD_NUMBER};
  assign val_four  = {ADDR_BLOCK_LOG2, MAKER_CONTINUATION_COUNT};
  assign val_five  = {PRIVATE_COUNT[2:0], SOFT_COUNT};
  assign val_six   = {SHARED_COUNT[5:0], PRIVATE_COUNT[4:3]};
  assign val_seven = {SECURITY_STATE_COUNT, PRIORITY_CODE, SHARED_COUNT[9:6]};

  pcid_byte_reg u_two (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .value (val_two),
    .word  (word_two)
  );

  pcid_byte_reg u_three (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .value (val_three),
    .word  (word_three)
  );

  pcid_byte_reg u_four (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .value (val_four),
    .word  (word_four)
  );

  pcid_byte_reg u_five (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .value (val_five),
    .word  (word_five)
  );

  pcid_byte_reg u_six (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .value (val_six),
    .word  (word_six)
  );

  pcid_byte_reg u_seven (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .value (val_seven),
    .word  (word_seven)
  );

  // Security and priority sit at the top of the combined word
  assign config_word = {word_seven[7:0], word_six[7:0], word_five[7:0], word_four[7:0]};

  // Read data registered in setup so access has no wait state;
  // a setup frozen by CLK_EN captures in access instead, one wait state later
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    valid_next = valid_reg;
    if (CLK_EN && PSEL && (!PENABLE || !valid_reg)) begin
      valid_next = 1'b1;
      err_next   = 1'b0;
      rdata_next = UNMAPPED_READ;
      if (PWRITE) begin
        rdata_next = UNMAPPED_READ;
      end else begin
        case (PADDR)
          OFF_IDENT_BYTE_TWO:   rdata_next = word_two;
          OFF_IDENT_BYTE_THREE: rdata_next = word_three;
          OFF_IDENT_BYTE_FOUR:  rdata_next = word_four;
          OFF_IDENT_BYTE_FIVE:  rdata_next = word_five;
          OFF_IDENT_BYTE_SIX:   rdata_next = word_six;
          OFF_IDENT_BYTE_SEVEN: rdata_next = word_seven;
          OFF_CONFIG_WORD:      rdata_next = config_word;
          default:              err_next   = 1'b1;
        endcase
      end
    end
    if (CLK_EN && PSEL && PENABLE && valid_reg) begin
      valid_next = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
      valid_reg <= valid_next;
    end
  end

  // Frozen clock enable, or data not yet captured, stalls the access phase
  assign PREADY  = CLK_EN && valid_reg;
  assign PRDATA  = (PSEL && PENABLE) ? rdata_reg : 32'h0000_0000;
  assign PSLVERR = PSEL && PENABLE && err_reg;

endmodule // pcid_regs

// file: design/pcid_pkg.sv
// Package for the configuration identification register bank.
// Assumes a 32-bit APB slave with word-aligned registers.
package pcid_pkg;

  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 32;

  // Register byte offsets
  localparam logic [11:0] OFF_IDENT_BYTE_TWO   = 12'h000;
  localparam logic [11:0] OFF_IDENT_BYTE_THREE = 12'h004;
  localparam logic [11:0] OFF_IDENT_BYTE_FOUR  = 12'h008;
  localparam logic [11:0] OFF_IDENT_BYTE_FIVE  = 12'h00C;
  localparam logic [11:0] OFF_IDENT_BYTE_SIX   = 12'h010;
  localparam logic [11:0] OFF_IDENT_BYTE_SEVEN = 12'h014;
  localparam logic [11:0] OFF_CONFIG_WORD      = 12'h018;

  // Third byte fields
  localparam logic [3:0] ARCH_VERSION        = 4'h0;
  localparam logic       MAKER_ALLOCATED     = 1'h1;
  // Arbitrary neutral maker code value
  localparam logic [2:0] MAKER_CODE_HIGH     = 3'h5;
  // Fourth byte fields
  localparam logic [3:0] METAL_FIX_DEFAULT   = 4'h0;
  localparam logic [3:0] MOD_NUMBER          = 4'h0;
  // Fifth byte fields
  localparam logic [3:0] ADDR_BLOCK_LOG2     = 4'h0;
  // Arbitrary neutral continuation count
  localparam logic [3:0] MAKER_CONTINUATION_COUNT = 4'h2;

  // Build configuration
  localparam logic       SECURITY_STATE_COUNT = 1'h1;
  localparam logic [2:0] PRIORITY_CODE        = 3'h4;
  localparam logic [9:0] SHARED_COUNT         = 10'h3DC;
  localparam logic [4:0] PRIVATE_COUNT        = 5'h10;
  localparam logic [4:0] SOFT_COUNT           = 5'h10;

  // Configuration word field positions
  localparam int unsigned CFG_SEC_BIT    = 31;
  localparam int unsigned CFG_PRIO_LSB   = 28;
  localparam int unsigned CFG_SHARED_LSB = 18;
  localparam int unsigned CFG_PRIV_LSB   = 13;

  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

endpackage : pcid_pkg

// file: design/pcid_byte_reg.sv
// One read-only identification byte register.
// Assumes bits above the low byte may read as anything; zero is given.
`timescale 1ns/1ps
module pcid_byte_reg (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  value,
  output logic      [31:0] word
);
  import pcid_pkg::*;

  logic [7:0] byte_reg;
  logic [7:0] byte_next;

  always_comb begin
    byte_next = byte_reg;
    if (ce) begin
      byte_next = value;
    end
  end

  // Value reloads from tie-offs; no write path exists
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Fields define the reset value, so reset loads the tie-offs directly
      byte_reg <= value;
    end else begin
      byte_reg <= byte_next;
    end
  end

  assign word = {24'h000000, byte_reg};

endmodule // pcid_byte_reg

// file: tb/pcid_regs_chk.sv
// Assertion checker for the identification register bank.
// Bound to pcid_regs; sees CLK_EN and its APB ports except PWDATA only.
`timescale 1ns/1ps
module pcid_regs_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  input wire logic [11:0] PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Low page, aligned words only, so of the unmapped reads only word 7 (0x01C) stays in
  wire logic       rd = PSEL && PENABLE && !PWRITE && PREADY && PADDR[11:5] == 7'h00 && PADDR[1:0] == 2'h0;
  wire logic [2:0] w  = PADDR[4:2];
  wire logic [7:0] b  = PRDATA[7:0];
  a_byte_two: assert property (rd && w == 3'h0 |-> b == 8'h0D)
    else $error("byte two");
  a_byte_four: assert property (rd && w == 3'h2 |-> b == 8'h02)
    else $error("byte four");
  a_byte_five: assert property (rd && w == 3'h3 |-> b == 8'h10)
    else $error("byte five");
  a_byte_six: assert property (rd && w == 3'h4 |-> b == 8'h72)
    else $error("byte six");
  a_byte_seven: assert property (rd && w == 3'h5 |-> b == 8'hCF)
    else $error("byte seven");
  a_config_word: assert property (rd && w == 3'h6 |-> PRDATA == 32'hCF72_1002)
    else $error("config word");
  a_write_quiet: assert property (PSEL && PENABLE && PWRITE |-> !PSLVERR)
    else $error("write error");
  a_mapped_ok: assert property (rd && w != 3'h7 |-> !PSLVERR)
    else $error("mapped error");
  cover property (rd && w == 3'h6);
  cover property (PSEL && PENABLE && !PREADY);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule // pcid_regs_chk

// file: tb/pcid_regs_test.sv
// Self-checking APB bench for the identification register bank.
// Expects pcid_regs values to follow its package constants.
`timescale 1ns/1ps
module pcid_regs_test;
  import pcid_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0]  rev = 4'hA;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er;
  int          errors = 0, total_checks = 0;
  wire logic [31:0] cfg = {SECURITY_STATE_COUNT, PRIORITY_CODE, SHARED_COUNT, PRIVATE_COUNT, SOFT_COUNT,
    ADDR_BLOCK_LOG2, MAKER_CONTINUATION_COUNT};
  pcid_regs i_pcid_regs (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .METAL_FIX_REVISION(rev),
    .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Stall s keeps CLK_EN low for s access cycles; s below zero freezes the setup cycle
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input int s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    clk_en <= (s >= 0);
    @(posedge clk);
    penable <= 1'b1;
    clk_en <= (s <= 0);
    do begin
      @(posedge clk);
      n++;
      if (n == s) clk_en <= 1'b1;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic rdb(input logic [11:0] a, input logic [7:0] v);
    xfer(1'b0, a, 32'h0, 0);
    chk({24'h0, rd[7:0]}, {24'h0, v});
    chk({31'h0, er}, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdb(OFF_IDENT_BYTE_TWO, {ARCH_VERSION, MAKER_ALLOCATED, MAKER_CODE_HIGH});
    rdb(OFF_IDENT_BYTE_THREE, {rev, MOD_NUMBER});
    rdb(OFF_IDENT_BYTE_FOUR, {ADDR_BLOCK_LOG2, MAKER_CONTINUATION_COUNT});
    rdb(OFF_IDENT_BYTE_FIVE, {PRIVATE_COUNT[2:0], SOFT_COUNT});
    rdb(OFF_IDENT_BYTE_SIX, {SHARED_COUNT[5:0], PRIVATE_COUNT[4:3]});
    rdb(OFF_IDENT_BYTE_SEVEN, {SECURITY_STATE_COUNT, PRIORITY_CODE, SHARED_COUNT[9:6]});
    xfer(1'b0, OFF_CONFIG_WORD, 32'h0, 2);
    chk(rd, cfg);
    chk({24'h0, rd[31:28], rd[7:4]}, 32'h0000_00C0);
    $display("test id values done");
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 12'(i * 4), 32'hFFFF_FFFF, 0);
      chk({31'h0, er}, 32'h0);
    end
    xfer(1'b0, OFF_CONFIG_WORD, 32'h0, 0);
    chk(rd, cfg);
    $display("test writes done");
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, i ? 12'hFFC : 12'h01C, 32'h0, 0);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
    end
    xfer(1'b0, OFF_CONFIG_WORD, 32'h0, -1);
    chk(rd, cfg);
    $display("test unmapped and frozen setup done");
    rev <= 4'h5;
    repeat (4) @(posedge clk);
    rdb(OFF_IDENT_BYTE_THREE, {4'h5, MOD_NUMBER});
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(1'b0, OFF_CONFIG_WORD, 32'h0, 0);
    chk(rd, cfg);
    $display("test revision and reset done");
    tally_and_finish();
  end
endmodule // pcid_regs_test
bind pcid_regs pcid_regs_chk i_pcid_regs_chk (.SYS_CLK, .RST_N, .CLK_EN, .PADDR, .PSEL, .PENABLE, .PWRITE,
  .PRDATA, .PREADY, .PSLVERR);
